// *** io_port_watchdog_timer.sv ***
// top of the i/o-port watchdog: countdown core and timeout action.
// assumes isa pins and jumpers arrive asynchronously to core_clk_i.
//
// Notes on behaviour
// - a read of port 443h arms the watchdog and starts the countdown
// - each further read of 443h reloads the countdown; software must repeat
// - a read of the disable port stops the countdown, no action follows
// - on expiry pulse cold reset or nmi, as the action jumper selects
// - countdown length comes only from the period jumpers
// - disable is decoded at both 043h and 843h
`timescale 1ns/1ps
module io_port_watchdog_timer #(
	parameter int          TICK_CYCLES = wdt_pkg::TICK_CYCLES,
	parameter logic [15:0] PERIOD_MS_0 = wdt_pkg::PERIOD_MS_0,
	parameter logic [15:0] PERIOD_MS_1 = wdt_pkg::PERIOD_MS_1,
	parameter logic [15:0] PERIOD_MS_2 = wdt_pkg::PERIOD_MS_2,
	parameter logic [15:0] PERIOD_MS_3 = wdt_pkg::PERIOD_MS_3
) (
	// clock and reset
	input  wire logic        core_clk_i,
	input  wire logic        reset_i,
	// isa i/o bus
	input  wire logic [15:0] isa_addr_i,
	input  wire logic        isa_ior_n_i,
	input  wire logic        isa_aen_i,
	// jumpers
	input  wire logic        timeout_action_select_jumper_i,
	input  wire logic [1:0]  timeout_period_select_jumpers_i,
	// timeout actions and status
	output logic             cold_reset_o,
	output logic             nmi_o,
	output logic             armed_o
);

	typedef enum logic [1:0] {
		WD_IDLE,
		WD_RUN,
		WD_FIRE
	} wd_state_e;

	typedef struct packed {
		wd_state_e   state;
		logic [15:0] prescale;
		logic [15:0] ms_left;
		logic [7:0]  pulse_cnt;
		logic        cold_reset;
		logic        nmi;
		logic        armed;
	} core_s;

	localparam logic [15:0] TICK_LAST  = 16'(TICK_CYCLES - 1);
	localparam logic [7:0]  PULSE_LAST = 8'(wdt_pkg::PULSE_CYCLES - 1);

	core_s       st_ff;
	core_s       nxt_st;
	logic [15:0] period_ms;
	logic        tick;
	logic        expire;
	logic [wdt_pkg::IN_W-1:0] pins;

	wdt_cmd_if cmd_if ();

	////////////////////////////////////////////////////////////////////////
	assign pins = {timeout_period_select_jumpers_i,
		timeout_action_select_jumper_i, isa_aen_i, isa_ior_n_i, isa_addr_i};

	wdt_bus_front u_front (
		.core_clk_i (core_clk_i),
		.reset_i    (reset_i),
		.pins_i     (pins),
		.cmd        (cmd_if.front)
	);

	////////////////////////////////////////////////////////////////////////
	// period from the jumpers only; no software path can change it
	always_comb begin
		case (cmd_if.period_sel)
			2'h0:    period_ms = PERIOD_MS_0;
			2'h1:    period_ms = PERIOD_MS_1;
			2'h2:    period_ms = PERIOD_MS_2;
			default: period_ms = PERIOD_MS_3;
		endcase
	end

	assign tick   = st_ff.prescale == TICK_LAST;
	assign expire = st_ff.state == WD_RUN && tick
		&& st_ff.ms_left <= wdt_pkg::MS_ONE;

	always_comb begin
		nxt_st = st_ff;
		case (st_ff.state)
			WD_IDLE: begin
				if (cmd_if.refresh_p) begin
					nxt_st.state    = WD_RUN;
					nxt_st.ms_left  = period_ms;
					nxt_st.prescale = 16'h0000;
					nxt_st.armed    = 1'b1;
				end
			end
			WD_RUN: begin
				nxt_st.prescale = tick ? 16'h0000 : st_ff.prescale + 16'h0001;
				if (tick) begin
					nxt_st.ms_left = st_ff.ms_left - wdt_pkg::MS_ONE;
				end
				if (cmd_if.disable_p) begin
					nxt_st.state = WD_IDLE;
					nxt_st.armed = 1'b0;
				end else if (cmd_if.refresh_p) begin
					nxt_st.ms_left  = period_ms;
					nxt_st.prescale = 16'h0000;
				end else if (expire) begin
					// action chosen at expiry; a later jumper change is moot
					nxt_st.state      = WD_FIRE;
					nxt_st.pulse_cnt  = 8'h00;
					nxt_st.cold_reset = !cmd_if.nmi_sel;
					nxt_st.nmi        = cmd_if.nmi_sel;
				end
			end
			WD_FIRE: begin
				// the action is committed: refresh and disable are ignored
				nxt_st.pulse_cnt = st_ff.pulse_cnt + 8'h01;
				if (st_ff.pulse_cnt == PULSE_LAST) begin
					nxt_st.state      = WD_IDLE;
					nxt_st.cold_reset = 1'b0;
					nxt_st.nmi        = 1'b0;
					nxt_st.armed      = 1'b0;
				end
			end
			default: begin
				nxt_st.state = WD_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			st_ff <= '{state: WD_IDLE, prescale: 16'h0000,
				ms_left: wdt_pkg::MS_ZERO, pulse_cnt: 8'h00,
				cold_reset: 1'b0, nmi: 1'b0, armed: 1'b0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign cold_reset_o = st_ff.cold_reset;
	assign nmi_o        = st_ff.nmi;
	assign armed_o      = st_ff.armed;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (reset_i);

	sequence s_running_refresh;
		st_ff.state == WD_RUN && cmd_if.refresh_p && !cmd_if.disable_p;
	endsequence

	sequence s_expiry_reset;
		expire && !cmd_if.disable_p && !cmd_if.refresh_p && !cmd_if.nmi_sel;
	endsequence

	sequence s_expiry_nmi;
		expire && !cmd_if.disable_p && !cmd_if.refresh_p && cmd_if.nmi_sel;
	endsequence

	a_enable_arms: assert property (
		st_ff.state == WD_IDLE && cmd_if.refresh_p
		|=> armed_o && st_ff.ms_left == $past(period_ms)
	) else $error("enable read did not arm the countdown");

	a_refresh_reloads: assert property (
		s_running_refresh |=> st_ff.ms_left == $past(period_ms)
		&& st_ff.prescale == 16'h0000 && st_ff.state == WD_RUN
	) else $error("refresh did not reload the countdown");

	a_disable_stops: assert property (
		st_ff.state == WD_RUN && cmd_if.disable_p
		|=> !armed_o && !cold_reset_o && !nmi_o ##1 !cold_reset_o && !nmi_o
	) else $error("disable read did not stop the watchdog");

	a_reset_action: assert property (
		s_expiry_reset |=> (cold_reset_o && !nmi_o) [*8]
	) else $error("expiry did not hold cold reset");

	a_nmi_action: assert property (
		s_expiry_nmi |=> (nmi_o && !cold_reset_o) [*8]
	) else $error("expiry did not hold nmi");

	a_pulse_ends: assert property (
		$rose(cold_reset_o) || $rose(nmi_o)
		|-> ##[40:41] !cold_reset_o && !nmi_o && !armed_o
	) else $error("timeout pulse has wrong length");

	a_period_static: assert property (
		st_ff.ms_left > $past(st_ff.ms_left)
		|-> $past(cmd_if.refresh_p) && st_ff.ms_left == $past(period_ms)
	) else $error("countdown grew without a refresh");

	a_reset_disarmed: assert property (
		$past(reset_i) |-> !armed_o && !cold_reset_o && !nmi_o
		&& st_ff.state == WD_IDLE
	) else $error("watchdog not idle after reset");

	a_idle_quiet: assert property (
		st_ff.state == WD_IDLE && !cmd_if.refresh_p
		|=> st_ff.state == WD_IDLE && !cold_reset_o && !nmi_o
	) else $error("idle watchdog acted without an enable read");

	// a refresh in the same cycle takes precedence over the step; a disable still steps ms_left but ends the run
	a_countdown_step: assert property (
		st_ff.state == WD_RUN && tick && !expire
		&& !cmd_if.refresh_p && !cmd_if.disable_p
		|=> st_ff.ms_left == $past(st_ff.ms_left) - wdt_pkg::MS_ONE
	) else $error("countdown did not step on a tick");

	a_one_action: assert property (
		!(cold_reset_o && nmi_o)
	) else $error("cold reset and nmi raised together");

	a_fire_committed: assert property (
		st_ff.state == WD_FIRE && st_ff.pulse_cnt != PULSE_LAST
		|=> st_ff.state == WD_FIRE
	) else $error("timeout pulse cut short");

endmodule : io_port_watchdog_timer

// *** wdt_pkg.sv ***
// constants for the i/o-port watchdog: port addresses, pin vector layout,
// timing counts.
// assumes a 40 MHz core clock and a 16-bit isa i/o address.
package wdt_pkg;

	localparam int          CLK_HZ          = 40_000_000;
	localparam int          CLK_PERIOD_NS   = 25;

	// i/o port addresses
	localparam logic [15:0] ENABLE_ADDR     = 16'h0443;
	localparam logic [15:0] DISABLE_ADDR_LO = 16'h0043;
	localparam logic [15:0] DISABLE_ADDR_HI = 16'h0843;

	// layout of the sampled pin vector
	localparam int          ADDR_W          = 16;
	localparam int          POS_ADDR        = 0;
	localparam int          POS_IOR_N       = 16;
	localparam int          POS_AEN         = 17;
	localparam int          POS_ACT         = 18;
	localparam int          POS_PER         = 19;
	localparam int          PER_W           = 2;
	localparam int          IN_W            = 21;
	// idle bus: read strobe high, everything else low
	localparam logic [20:0] PIN_RESET       = 21'h010000;

	// countdown timebase: one tick per millisecond
	localparam int          TICK_MS_PER     = 1;
	localparam int          TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS_PER;
	localparam int          CNT_W           = 16;

	// timeout periods in milliseconds per period jumper setting
	localparam logic [15:0] PERIOD_MS_0     = 16'h03e8;
	localparam logic [15:0] PERIOD_MS_1     = 16'h07d0;
	localparam logic [15:0] PERIOD_MS_2     = 16'h1388;
	localparam logic [15:0] PERIOD_MS_3     = 16'h2710;

	// least width of the reset or nmi pulse
	localparam int          PULSE_NS        = 1000;
	localparam int          PULSE_CYCLES    =
		(PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam logic [15:0] MS_ZERO         = 16'h0000;
	localparam logic [15:0] MS_ONE          = 16'h0001;

endpackage : wdt_pkg

// *** wdt_cmd_if.sv ***
// carrier between the bus front end and the countdown core.
// assumes both ends run on core_clk_i.
`timescale 1ns/1ps
interface wdt_cmd_if;
	logic       refresh_p;
	logic       disable_p;
	logic       nmi_sel;
	logic [1:0] period_sel;

	modport front (
		output refresh_p,
		output disable_p,
		output nmi_sel,
		output period_sel
	);
	modport core (
		input  refresh_p,
		input  disable_p,
		input  nmi_sel,
		input  period_sel
	);
endinterface : wdt_cmd_if

// *** wdt_bus_front.sv ***
// isa pin synchroniser and i/o read decoder for the watchdog ports.
// assumes the address is stable for the whole read strobe.
`timescale 1ns/1ps
module wdt_bus_front (
	// clock and reset
	input  wire logic                      core_clk_i,
	input  wire logic                      reset_i,
	// isa and jumper pins
	input  wire logic [wdt_pkg::IN_W-1:0]  pins_i,
	// decoded commands
	wdt_cmd_if.front                       cmd
);

	typedef struct packed {
		logic [wdt_pkg::IN_W-1:0] s1;
		logic [wdt_pkg::IN_W-1:0] s2;
		logic [wdt_pkg::IN_W-1:0] s3;
		logic [wdt_pkg::IN_W-1:0] filt;
		logic                     refresh_p;
		logic                     disable_p;
	} front_s;

	front_s                   st_ff;
	front_s                   nxt_st;
	logic [wdt_pkg::IN_W-1:0] agree;
	logic [15:0]              addr;
	logic                     rd_fall;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		nxt_st           = st_ff;
		nxt_st.s1        = pins_i;
		nxt_st.s2        = st_ff.s1;
		nxt_st.s3        = st_ff.s2;
		// a bit only moves once two later stages agree, masking glitches
		agree            = ~(st_ff.s2 ^ st_ff.s3);
		nxt_st.filt      = (agree & st_ff.s3) | (~agree & st_ff.filt);
		addr             = nxt_st.filt[wdt_pkg::POS_ADDR +: wdt_pkg::ADDR_W];
		// one decode per strobe; dma cycles (aen high) are not ours
		rd_fall          = st_ff.filt[wdt_pkg::POS_IOR_N]
			&& !nxt_st.filt[wdt_pkg::POS_IOR_N]
			&& !nxt_st.filt[wdt_pkg::POS_AEN];
		nxt_st.refresh_p = rd_fall && addr == wdt_pkg::ENABLE_ADDR;
		nxt_st.disable_p = rd_fall
			&& (addr == wdt_pkg::DISABLE_ADDR_LO
			|| addr == wdt_pkg::DISABLE_ADDR_HI);
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			st_ff <= '{s1: wdt_pkg::PIN_RESET, s2: wdt_pkg::PIN_RESET,
				s3: wdt_pkg::PIN_RESET, filt: wdt_pkg::PIN_RESET,
				refresh_p: 1'b0, disable_p: 1'b0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign cmd.refresh_p  = st_ff.refresh_p;
	assign cmd.disable_p  = st_ff.disable_p;
	assign cmd.nmi_sel    = st_ff.filt[wdt_pkg::POS_ACT];
	assign cmd.period_sel = st_ff.filt[wdt_pkg::POS_PER +: wdt_pkg::PER_W];

endmodule : wdt_bus_front

// *** isa_host_model.sv ***
// host cpu model: plain isa i/o reads toward the watchdog ports.
// assumes the caller runs on core_clk_i and calls io_read one at a time.
`timescale 1ns/1ps
module isa_host_model (
	// clock
	input  wire logic        core_clk_i,
	// isa i/o bus
	output logic      [15:0] isa_addr_o,
	output logic             isa_ior_n_o,
	output logic             isa_aen_o
);
	////////////////////////////////////////////////////////////////////////
	initial begin
		isa_addr_o  = 16'h0000;
		isa_ior_n_o = 1'b1;
		isa_aen_o   = 1'b0;
	end

	// strobe held 4 cycles low and 4 high so each read is seen once;
	// callers space refreshes well inside 70% of the period
	// callers end the refresh runs with a disable read; other armed runs end by expiry or by reset
	task automatic io_read(input logic [15:0] addr, input logic aen);
		@(negedge core_clk_i);
		isa_addr_o  = addr;
		isa_aen_o   = aen;
		isa_ior_n_o = 1'b0;
		repeat (4) @(negedge core_clk_i);
		isa_ior_n_o = 1'b1;
		// released address no longer shows the last value
		isa_addr_o  = ~addr;
		isa_aen_o   = 1'b0;
		repeat (4) @(negedge core_clk_i);
	endtask : io_read
endmodule : isa_host_model

// *** io_port_watchdog_timer_test.sv ***
// self-checking bench for the i/o-port watchdog.
// assumes ticks shortened to 4 cycles and periods of 20..50 ticks.
`timescale 1ns/1ps
module io_port_watchdog_timer_test;
	logic        core_clk;
	logic        reset;
	logic [15:0] isa_addr;
	logic        isa_ior_n;
	logic        isa_aen;
	logic        act_sel;
	logic [1:0]  per_sel;
	logic        cold_reset;
	logic        nmi;
	logic        armed;
	logic        fired;
	int          err_count;
	int          checks;
	int          n;
	int          w;
	int          per [4] = '{20, 30, 40, 50};
	logic [15:0] dis [2] = '{wdt_pkg::DISABLE_ADDR_LO,
		wdt_pkg::DISABLE_ADDR_HI};

	////////////////////////////////////////////////////////////////////////
	isa_host_model host (
		.core_clk_i  (core_clk),
		.isa_addr_o  (isa_addr),
		.isa_ior_n_o (isa_ior_n),
		.isa_aen_o   (isa_aen)
	);

	io_port_watchdog_timer #(
		.TICK_CYCLES (4),
		.PERIOD_MS_0 (16'h0014),
		.PERIOD_MS_1 (16'h001e),
		.PERIOD_MS_2 (16'h0028),
		.PERIOD_MS_3 (16'h0032)
	) DUT (
		.core_clk_i                      (core_clk),
		.reset_i                         (reset),
		.isa_addr_i                      (isa_addr),
		.isa_ior_n_i                     (isa_ior_n),
		.isa_aen_i                       (isa_aen),
		.timeout_action_select_jumper_i  (act_sel),
		.timeout_period_select_jumpers_i (per_sel),
		.cold_reset_o                    (cold_reset),
		.nmi_o                           (nmi),
		.armed_o                         (armed)
	);

	////////////////////////////////////////////////////////////////////////
	initial core_clk = 1'b0;
	always #12.5 core_clk = ~core_clk;

	// sticky record of any timeout pulse
	always @(posedge core_clk) begin
		if (cold_reset === 1'b1 || nmi === 1'b1)
			fired <= 1'b1;
	end

	task automatic wrap_up;
		if (err_count == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : wrap_up

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask : chk

	// bounded wait for a pulse; a hang goes straight to the report
	task automatic wait_fire(output int cnt);
		cnt = 0;
		while (!(cold_reset === 1'b1 || nmi === 1'b1) && cnt < 1000) begin
			@(negedge core_clk);
			cnt++;
		end
		if (cnt >= 1000) begin
			err_count++;
			$display("BAD %0t no timeout pulse", $time);
			wrap_up();
		end
	endtask : wait_fire

	////////////////////////////////////////////////////////////////////////
	initial begin
		err_count = 0;
		checks    = 0;
		fired     = 1'b0;
		reset     = 1'b1;
		act_sel   = 1'b0;
		per_sel   = 2'h0;
		repeat (16) @(negedge core_clk);
		reset = 1'b0;
		repeat (300) @(negedge core_clk);
		chk({fired, armed}, 2'h0);
		// stray reads: other address, dma cycle, disable while idle
		host.io_read(16'h0543, 1'b0);
		host.io_read(wdt_pkg::ENABLE_ADDR, 1'b1);
		host.io_read(wdt_pkg::DISABLE_ADDR_LO, 1'b0);
		repeat (250) @(negedge core_clk);
		chk({fired, armed}, 2'h0);
		// every period setting, both actions
		for (int i = 0; i < 4; i++) begin
			per_sel = i[1:0];
			act_sel = i[0];
			repeat (8) @(negedge core_clk);
			host.io_read(wdt_pkg::ENABLE_ADDR, 1'b0);
			chk(armed, 1'b1);
			wait_fire(n);
			chk(n >= per[i] * 4 - 4 && n <= per[i] * 4 + 2, 1'b1);
			chk({cold_reset, nmi}, {~act_sel, act_sel});
			w = 0;
			while ((cold_reset === 1'b1 || nmi === 1'b1) && w < 100) begin
				@(negedge core_clk);
				w++;
			end
			chk(w, 40);
			chk(armed, 1'b0);
			fired = 1'b0;
		end
		// refresh keeps it alive; then either disable address stops it
		per_sel = 2'h0;
		for (int d = 0; d < 2; d++) begin
			host.io_read(wdt_pkg::ENABLE_ADDR, 1'b0);
			for (int k = 0; k < 5; k++) begin
				repeat (40) @(negedge core_clk);
				host.io_read(wdt_pkg::ENABLE_ADDR, 1'b0);
			end
			chk({fired, armed}, 2'h1);
			host.io_read(dis[d], 1'b0);
			repeat (250) @(negedge core_clk);
			chk({fired, armed}, 2'h0);
		end
		// a reset in mid-run disarms; the period runs out with no action
		host.io_read(wdt_pkg::ENABLE_ADDR, 1'b0);
		chk(armed, 1'b1);
		reset = 1'b1;
		repeat (16) @(negedge core_clk);
		reset = 1'b0;
		repeat (250) @(negedge core_clk);
		chk({fired, armed}, 2'h0);
		wrap_up();
	end
endmodule : io_port_watchdog_timer_test
